// [hw/asre_params.svh]
`ifndef ASRE_PARAMS_SVH
`define ASRE_PARAMS_SVH

// Register byte addresses
`define ASRE_A_CTRL 8'h00
`define ASRE_A_CMD 8'h04
`define ASRE_A_VMAX 8'h08
`define ASRE_A_JOG1F 8'h0c
`define ASRE_A_JOG1R 8'h10
`define ASRE_A_JOG2F 8'h14
`define ASRE_A_JOG2R 8'h18
`define ASRE_A_VINC 8'h1c
`define ASRE_A_VREF1 8'h20
`define ASRE_A_VREF2 8'h24
`define ASRE_A_PPR 8'h28
`define ASRE_A_DPR 8'h2c
`define ASRE_A_TARGET 8'h30
`define ASRE_A_OFFSET 8'h34
`define ASRE_A_REFPT 8'h38
`define ASRE_A_POS 8'h3c
`define ASRE_A_STATUS 8'h40
`define ASRE_A_RESOL 8'h44
`define ASRE_A_SPEED 8'h48

// Control register fields
`define ASRE_C_BCD 0
`define ASRE_C_REFREV 1
`define ASRE_C_LIMNEG 2
`define ASRE_C_EVAL_LO 3
`define ASRE_C_EVAL_HI 4

// Status register fields
`define ASRE_S_BUSY 0
`define ASRE_S_REFOK 1
`define ASRE_S_LIMFWD 2
`define ASRE_S_LIMREV 3
`define ASRE_S_CFGERR 4

// Command codes
`define ASRE_CMD_STOP 3'h0
`define ASRE_CMD_JOG1F 3'h1
`define ASRE_CMD_JOG1R 3'h2
`define ASRE_CMD_JOG2F 3'h3
`define ASRE_CMD_JOG2R 3'h4
`define ASRE_CMD_INCREL 3'h5
`define ASRE_CMD_INCABS 3'h6
`define ASRE_CMD_REF 3'h7

// Scaling and ranges
`define ASRE_FULL_MV 10000
`define ASRE_DAC_FULL 16'h7fff
`define ASRE_SPD_MIN 16'h0001
`define ASRE_PPR_MAX 16'hfde8
`define ASRE_DPR_MAX 19'h61a80
`define ASRE_DPR_MIN 19'h00001
`define ASRE_RES_FRAC 16
`define ASRE_BCD_DIGITS 7

// Reset values
`define ASRE_RST_SPD 16'h0000
`define ASRE_RST_PPR 16'h0001
`define ASRE_RST_DPR 19'h00001

`endif

// [hw/asre_pkg.sv]
package asre_pkg;

  typedef enum logic [1:0] {
    ASRE_EVAL_X1,
    ASRE_EVAL_X2,
    ASRE_EVAL_X4,
    ASRE_EVAL_RSV
  } asre_eval_e;

  typedef enum {
    ASRE_IDLE,
    ASRE_JOG,
    ASRE_INC,
    ASRE_REF_BACK,
    ASRE_REF_SEEK,
    ASRE_REF_ZERO
  } asre_state_e;

endpackage

// [hw/asre_div.sv]
`timescale 1ns/1ns
`default_nettype none

// Serial restoring divider, one quotient bit per enabled cycle
module asre_div #(
  parameter int NW = 32,
  parameter int DW = 16
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic [NW-1:0] num_i,
  input wire logic [DW-1:0] den_i,
  output logic busy_o,
  output logic done_o,
  output logic [NW-1:0] quo_o
);
  localparam int CW = $clog2(NW + 1);
  logic [DW-1:0] den_q;
  logic [DW:0] rem_q;
  logic [CW-1:0] cnt_q;
  logic [DW:0] next_rem;
  logic ge;

  // Trial subtraction of the shifted remainder
  always_comb
  begin
    next_rem = {rem_q[DW-1:0], quo_o[NW-1]};
    ge = (next_rem >= {1'b0, den_q});
  end

  // Shift quotient in, reduce remainder
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      quo_o <= '0;
      den_q <= '0;
      rem_q <= '0;
      cnt_q <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end
    else if (ce_i)
    begin
      done_o <= 1'b0;
      if (!busy_o && start_i)
      begin
        quo_o <= num_i;
        den_q <= den_i;
        rem_q <= '0;
        cnt_q <= CW'(NW);
        busy_o <= 1'b1;
      end
      else if (busy_o)
      begin
        quo_o <= {quo_o[NW-2:0], ge};
        rem_q <= ge ? next_rem - {1'b0, den_q} : next_rem;
        cnt_q <= cnt_q - 1'b1;
        if (cnt_q == CW'(1))
        begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// [hw/asre_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "asre_params.svh"

module asre_top
  import asre_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic enc_z_i,
  input wire logic precontact_i,
  input wire logic limit_fwd_i,
  input wire logic limit_rev_i,
  output logic [15:0] speed_o,
  output logic drive_en_o
);
  // Signed seven-digit BCD with sign in bit 31
  function automatic logic [31:0] bcd2bin(input logic [31:0] v);
    logic [31:0] acc;
    acc = '0;
    for (int i = `ASRE_BCD_DIGITS - 1; i >= 0; i--)
      acc = 32'(acc * 32'd10) + {28'h0, v[i*4 +: 4]};
    return v[31] ? 32'(-acc) : acc;
  endfunction

  // Speed in range: above one and not above a bound
  function automatic logic spd_bad(input logic [15:0] v, input logic [15:0] lim);
    return (v <= `ASRE_SPD_MIN) || (v > lim);
  endfunction

  logic [4:0] ctrl;
  logic [15:0] vmax, jog1f, jog1r, jog2f, jog2r, vinc, vref1, vref2, ppr;
  logic [18:0] dpr;
  logic [31:0] target, offset, refpt, pos, goal, resol;
  logic ref_ok, lim_fwd_flag, lim_rev_flag;
  logic [2:0] a_s, b_s, z_s, pc_s, lf_s, lr_s;
  asre_state_e state;
  logic move_rev;
  logic [15:0] next_spd;
  logic next_rev;
  logic cfg_err;
  logic jog_sel;
  logic a_ed, b_ed, step, up, zero_ed, lf_ed, lr_ed, hit_fwd, hit_rev;
  logic [31:0] cmd_goal;
  logic spd_busy, spd_done, spd_neg, res_busy, res_done;
  logic [30:0] spd_quo;
  logic [34:0] res_quo;
  logic [17:0] edges_rev;
  asre_eval_e eval;

  assign eval = asre_eval_e'(ctrl[`ASRE_C_EVAL_HI:`ASRE_C_EVAL_LO]);

  // Two-stage synchronisers plus one history stage for edge detection
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      a_s <= '0;
      b_s <= '0;
      z_s <= '0;
      pc_s <= '0;
      lf_s <= '0;
      lr_s <= '0;
    end
    else if (ce_i)
    begin
      a_s <= {a_s[1:0], enc_a_i};
      b_s <= {b_s[1:0], enc_b_i};
      z_s <= {z_s[1:0], enc_z_i};
      pc_s <= {pc_s[1:0], precontact_i};
      lf_s <= {lf_s[1:0], limit_fwd_i};
      lr_s <= {lr_s[1:0], limit_rev_i};
    end
  end

  // Edge qualification by evaluation mode and limit polarity
  always_comb
  begin
    a_ed = a_s[2] ^ a_s[1];
    b_ed = b_s[2] ^ b_s[1];
    up = a_s[1] ^ b_s[2];
    case (eval)
      ASRE_EVAL_X1: step = a_ed && a_s[1];
      ASRE_EVAL_X2: step = a_ed;
      default: step = a_ed || b_ed;
    endcase
    if (eval == ASRE_EVAL_X1)
      up = 1'b1 ^ b_s[1]; // A rising with B low counts up
    zero_ed = z_s[1] && !z_s[2];
    lf_ed = (lf_s[1] ^ lf_s[2]) && (lf_s[1] ^ ctrl[`ASRE_C_LIMNEG]);
    lr_ed = (lr_s[1] ^ lr_s[2]) && (lr_s[1] ^ ctrl[`ASRE_C_LIMNEG]);
    hit_fwd = lf_ed && !move_rev;
    hit_rev = lr_ed && move_rev;
  end

  // Configuration sanity, shown in status
  always_comb
  begin
    cfg_err = spd_bad(jog1f, vmax) || spd_bad(jog1r, vmax) || spd_bad(jog2f, vmax)
      || spd_bad(jog2r, vmax) || spd_bad(vinc, vmax) || spd_bad(vref1, vmax)
      || spd_bad(vref2, vmax) || (vref2 > vref1)
      || (ppr == 16'h0) || (ppr > `ASRE_PPR_MAX) || (dpr < `ASRE_DPR_MIN) || (dpr > `ASRE_DPR_MAX);
  end

  // Goal of an incremental move, decoded from the target and offset registers
  assign cmd_goal = ctrl[`ASRE_C_BCD] ? bcd2bin(target) + bcd2bin(offset) : target + offset;

  // Configuration registers written by software
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl <= '0;
      vmax <= `ASRE_RST_SPD;
      jog1f <= `ASRE_RST_SPD;
      jog1r <= `ASRE_RST_SPD;
      jog2f <= `ASRE_RST_SPD;
      jog2r <= `ASRE_RST_SPD;
      vinc <= `ASRE_RST_SPD;
      vref1 <= `ASRE_RST_SPD;
      vref2 <= `ASRE_RST_SPD;
      ppr <= `ASRE_RST_PPR;
      dpr <= `ASRE_RST_DPR;
      target <= '0;
      offset <= '0;
      refpt <= '0;
    end
    else if (ce_i && wr_i)
    begin
      if (addr_i == `ASRE_A_CTRL)
        ctrl <= wdata_i[4:0];
      else if (addr_i == `ASRE_A_VMAX)
        vmax <= wdata_i[15:0];
      else if (addr_i == `ASRE_A_JOG1F)
        jog1f <= wdata_i[15:0];
      else if (addr_i == `ASRE_A_JOG1R)
        jog1r <= wdata_i[15:0];
      else if (addr_i == `ASRE_A_JOG2F)
        jog2f <= wdata_i[15:0];
      else if (addr_i == `ASRE_A_JOG2R)
        jog2r <= wdata_i[15:0];
      else if (addr_i == `ASRE_A_VINC)
        vinc <= wdata_i[15:0];
      else if (addr_i == `ASRE_A_VREF1)
        vref1 <= wdata_i[15:0];
      else if (addr_i == `ASRE_A_VREF2)
        vref2 <= wdata_i[15:0];
      else if (addr_i == `ASRE_A_PPR)
        ppr <= wdata_i[15:0];
      else if (addr_i == `ASRE_A_DPR)
        dpr <= wdata_i[18:0];
      else if (addr_i == `ASRE_A_TARGET)
        target <= wdata_i;
      else if (addr_i == `ASRE_A_OFFSET)
        offset <= wdata_i;
      else if (addr_i == `ASRE_A_REFPT)
        refpt <= wdata_i;
    end
  end

  // Motion sequencer: jog, incremental and reference approach
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state <= ASRE_IDLE;
      move_rev <= 1'b0;
      goal <= '0;
      drive_en_o <= 1'b0;
    end
    else if (ce_i)
    begin
      drive_en_o <= (state != ASRE_IDLE);
      if (wr_i && addr_i == `ASRE_A_CMD)
      begin
        case (wdata_i[2:0])
          `ASRE_CMD_JOG1F, `ASRE_CMD_JOG2F:
          begin
            state <= ASRE_JOG;
            move_rev <= 1'b0;
          end
          `ASRE_CMD_JOG1R, `ASRE_CMD_JOG2R:
          begin
            state <= ASRE_JOG;
            move_rev <= 1'b1;
          end
          `ASRE_CMD_INCREL, `ASRE_CMD_INCABS:
          begin
            state <= ASRE_INC;
            goal <= (wdata_i[2:0] == `ASRE_CMD_INCREL) ? pos + cmd_goal : cmd_goal;
            move_rev <= (wdata_i[2:0] == `ASRE_CMD_INCREL) ? cmd_goal[31] : ($signed(cmd_goal) < $signed(pos));
          end
          `ASRE_CMD_REF:
          begin
            state <= ASRE_REF_BACK;
            move_rev <= !ctrl[`ASRE_C_REFREV];
          end
          default: state <= ASRE_IDLE;
        endcase
      end
      else
      begin
        case (state)
          ASRE_JOG:
            if (hit_fwd || hit_rev)
              state <= ASRE_IDLE;
          ASRE_INC:
            if (hit_fwd || hit_rev || pos == goal
                || (move_rev ? $signed(pos) < $signed(goal) : $signed(pos) > $signed(goal)))
              state <= ASRE_IDLE;
          ASRE_REF_BACK:
            if (hit_fwd || hit_rev)
            begin
              state <= ASRE_REF_SEEK;
              move_rev <= ctrl[`ASRE_C_REFREV];
            end
          ASRE_REF_SEEK:
            if (hit_fwd || hit_rev)
              state <= ASRE_IDLE;
            else if (pc_s[1])
              state <= ASRE_REF_ZERO;
          ASRE_REF_ZERO:
            if (hit_fwd || hit_rev || zero_ed)
              state <= ASRE_IDLE;
          default: state <= ASRE_IDLE;
        endcase
      end
    end
  end

  // Position counter, loaded with the reference point at the zero marker
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pos <= '0;
    else if (ce_i)
    begin
      if (state == ASRE_REF_ZERO && zero_ed)
        pos <= ctrl[`ASRE_C_BCD] ? bcd2bin(refpt) : refpt;
      else if (step)
        pos <= up ? pos + 32'h1 : pos - 32'h1;
    end
  end

  // Sticky flags; a new event wins over the clear
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ref_ok <= 1'b0;
      lim_fwd_flag <= 1'b0;
      lim_rev_flag <= 1'b0;
    end
    else if (ce_i)
    begin
      if (state == ASRE_REF_ZERO && zero_ed)
        ref_ok <= 1'b1;
      else if (wr_i && addr_i == `ASRE_A_CMD && wdata_i[2:0] == `ASRE_CMD_REF)
        ref_ok <= 1'b0;
      if (lf_ed)
        lim_fwd_flag <= 1'b1;
      else if (wr_i && addr_i == `ASRE_A_STATUS && wdata_i[`ASRE_S_LIMFWD])
        lim_fwd_flag <= 1'b0;
      if (lr_ed)
        lim_rev_flag <= 1'b1;
      else if (wr_i && addr_i == `ASRE_A_STATUS && wdata_i[`ASRE_S_LIMREV])
        lim_rev_flag <= 1'b0;
    end
  end

  // Speed selected for the present state
  always_comb
  begin
    next_rev = move_rev;
    case (state)
      ASRE_JOG: next_spd = jog_sel ? (move_rev ? jog2r : jog2f) : (move_rev ? jog1r : jog1f);
      ASRE_INC: next_spd = vinc;
      ASRE_REF_BACK, ASRE_REF_SEEK: next_spd = vref1;
      ASRE_REF_ZERO: next_spd = vref2;
      default: next_spd = 16'h0;
    endcase
    if (next_spd > vmax)
      next_spd = vmax;
  end

  // Jog speed set picked by the last command
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      jog_sel <= 1'b0;
    else if (ce_i && wr_i && addr_i == `ASRE_A_CMD)
      jog_sel <= (wdata_i[2:0] == `ASRE_CMD_JOG2F) || (wdata_i[2:0] == `ASRE_CMD_JOG2R);
  end

  // Speed scaling: vmax maps to full-scale output
  asre_div #(.NW(31), .DW(16)) u_spd_div (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .start_i(1'b1),
    .num_i(31'(next_spd * `ASRE_DAC_FULL)),
    .den_i(vmax),
    .busy_o(spd_busy),
    .done_o(spd_done),
    .quo_o(spd_quo)
  );

  // Direction captured with each division; output stops at once when idle
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      spd_neg <= 1'b0;
      speed_o <= '0;
    end
    else if (ce_i)
    begin
      if (!spd_busy)
        spd_neg <= next_rev;
      if (state == ASRE_IDLE)
        speed_o <= '0;
      else if (spd_done)
        speed_o <= spd_neg ? 16'(-spd_quo[15:0]) : spd_quo[15:0];
    end
  end

  // Counted edges per revolution and resolution in 16-bit fraction
  assign edges_rev = (eval == ASRE_EVAL_X1) ? {2'b00, ppr}
    : (eval == ASRE_EVAL_X2) ? {1'b0, ppr, 1'b0} : {ppr, 2'b00};

  asre_div #(.NW(35), .DW(18)) u_res_div (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .start_i(1'b1),
    .num_i({dpr, 16'h0}),
    .den_i(edges_rev),
    .busy_o(res_busy),
    .done_o(res_done),
    .quo_o(res_quo)
  );

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      resol <= '0;
    else if (ce_i && res_done)
      resol <= res_quo[31:0];
  end

  // Read port: data valid the cycle after the strobe, zero otherwise
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_o <= '0;
    else if (ce_i)
    begin
      rdata_o <= '0;
      if (rd_i)
      begin
        if (addr_i == `ASRE_A_CTRL)
          rdata_o <= {27'h0, ctrl};
        else if (addr_i == `ASRE_A_VMAX)
          rdata_o <= {16'h0, vmax};
        else if (addr_i == `ASRE_A_JOG1F)
          rdata_o <= {16'h0, jog1f};
        else if (addr_i == `ASRE_A_JOG1R)
          rdata_o <= {16'h0, jog1r};
        else if (addr_i == `ASRE_A_JOG2F)
          rdata_o <= {16'h0, jog2f};
        else if (addr_i == `ASRE_A_JOG2R)
          rdata_o <= {16'h0, jog2r};
        else if (addr_i == `ASRE_A_VINC)
          rdata_o <= {16'h0, vinc};
        else if (addr_i == `ASRE_A_VREF1)
          rdata_o <= {16'h0, vref1};
        else if (addr_i == `ASRE_A_VREF2)
          rdata_o <= {16'h0, vref2};
        else if (addr_i == `ASRE_A_PPR)
          rdata_o <= {16'h0, ppr};
        else if (addr_i == `ASRE_A_DPR)
          rdata_o <= {13'h0, dpr};
        else if (addr_i == `ASRE_A_TARGET)
          rdata_o <= target;
        else if (addr_i == `ASRE_A_OFFSET)
          rdata_o <= offset;
        else if (addr_i == `ASRE_A_REFPT)
          rdata_o <= refpt;
        else if (addr_i == `ASRE_A_POS)
          rdata_o <= pos;
        else if (addr_i == `ASRE_A_STATUS)
          rdata_o <= {27'h0, cfg_err, lim_rev_flag, lim_fwd_flag, ref_ok, state != ASRE_IDLE};
        else if (addr_i == `ASRE_A_RESOL)
          rdata_o <= resol;
        else if (addr_i == `ASRE_A_SPEED)
          rdata_o <= {16'h0, speed_o};
      end
    end
  end
endmodule

`default_nettype wire

// [tb/asre_top_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
`include "asre_params.svh"

// Port-level checks on the axis block
module asre_top_monitor (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [15:0] speed_o,
  input wire logic drive_en_o
);
  logic [2:0] cmd_q;
  logic cmd_wr;

  // A command write taken on this edge
  assign cmd_wr = wr_i && ce_i && addr_i == `ASRE_A_CMD;

  // Recent command writes, for the motion start latency
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cmd_q <= 3'h0;
    else
      cmd_q <= {cmd_q[1:0], cmd_wr};
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  chk_rdata_idle:
    assert property (ce_i && !rd_i |=> rdata_o == 32'h0) else $error("Read data not zero outside a read");
  chk_unmapped_zero:
    assert property (rd_i && ce_i && addr_i > `ASRE_A_SPEED |=> rdata_o == 32'h0) else $error("Unmapped read not zero");
  chk_vmax_readback:
    assert property (wr_i && ce_i && addr_i == `ASRE_A_VMAX ##1 rd_i && ce_i && addr_i == `ASRE_A_VMAX
      |=> rdata_o == ($past(wdata_i, 2) & 32'h0000ffff)) else $error("Maximum speed read back wrong");
  chk_speed_reg:
    assert property (rd_i && ce_i && addr_i == `ASRE_A_SPEED |=> rdata_o[15:0] == $past(speed_o))
    else $error("Speed register differs from speed output");
  chk_drive_start:
    assert property ($rose(drive_en_o) |-> cmd_q != 3'h0) else $error("Drive enabled without a command");
  chk_stop_cmd:
    assert property (cmd_wr && wdata_i[2:0] == `ASRE_CMD_STOP |-> ##[1:3] !drive_en_o)
    else $error("Stop command did not end motion");
  chk_idle_speed:
    assert property (!drive_en_o [*2] |-> speed_o == 16'h0) else $error("Speed output not zero while idle");
  chk_speed_active:
    assert property ($changed(speed_o) |-> drive_en_o || speed_o == 16'h0) else $error("Speed changed while idle");
endmodule

bind asre_top asre_top_monitor u_mon (.clock_i, .nrst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .speed_o, .drive_en_o);

`default_nettype wire

// [tb/asre_axis_model.sv]
`timescale 1ns/1ns
`default_nettype none

// Drive, incremental encoder, precontact and limit switches of one axis
module asre_axis_model (
  input wire logic clock_i,
  input wire logic [15:0] speed_i,
  input wire logic lim_neg_i,
  output logic enc_a_o,
  output logic enc_b_o,
  output logic enc_z_o,
  output logic pre_o,
  output logic lim_fwd_o,
  output logic lim_rev_o,
  output logic signed [31:0] mpos_o,
  output logic signed [31:0] cnt1_o,
  output logic signed [31:0] cnt2_o,
  output logic signed [31:0] cnt4_o
);
  logic [1:0] tick;
  logic fwd;
  logic [1:0] ph;
  logic signed [31:0] dir;

  initial
  begin
    tick = 2'h0;
    mpos_o = 32'sh0;
    cnt1_o = 32'sh0;
    cnt2_o = 32'sh0;
    cnt4_o = 32'sh0;
  end

  // Travel follows the sign of the speed command
  assign fwd = !speed_i[15];
  assign dir = fwd ? 32'sh1 : -32'sh1;
  assign ph = mpos_o[1:0];

  // Tracks, marker and switches from the axis position
  assign enc_a_o = ph[1] ^ ph[0];
  assign enc_b_o = ph[1];
  assign enc_z_o = mpos_o[4:0] == 5'h19 && !mpos_o[31];
  assign pre_o = mpos_o >= 32'sh1e && mpos_o <= 32'sh54;
  assign lim_fwd_o = (mpos_o >= 32'sh78) ^ lim_neg_i;
  assign lim_rev_o = (mpos_o <= -32'sh28) ^ lim_neg_i;

  // One encoder step each fourth cycle while commanded, with edge tallies
  always @(posedge clock_i)
  begin
    tick <= tick + 2'h1;
    if (tick == 2'h3 && speed_i != 16'h0)
    begin
      mpos_o <= mpos_o + dir;
      cnt4_o <= cnt4_o + dir;
      if (ph[0] != fwd)
        cnt2_o <= cnt2_o + dir;
      if (ph == {!fwd, !fwd})
        cnt1_o <= cnt1_o + dir;
    end
  end
endmodule

`default_nettype wire

// [tb/axis_speed_reference_encoder_setup_test.sv]
`timescale 1ns/1ns
`default_nettype none
`include "asre_params.svh"

module axis_speed_reference_encoder_setup_test;
  localparam logic [15:0] vmax_set = 16'hfffe;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr_i = 8'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic lim_neg = 1'b0;
  logic [31:0] rdata_o;
  logic [15:0] speed_o;
  logic drive_en_o, enc_a, enc_b, enc_z, pre, lim_f, lim_r;
  logic signed [31:0] mpos, c1, c2, c4;
  int num_errors = 0;
  int checks_done = 0;

  // Clock at 50 MHz
  always #10 clock_i = ~clock_i;

  asre_top DUT (.clock_i, .nrst_i, .ce_i(1'b1), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .enc_a_i(enc_a),
    .enc_b_i(enc_b), .enc_z_i(enc_z), .precontact_i(pre), .limit_fwd_i(lim_f), .limit_rev_i(lim_r), .speed_o,
    .drive_en_o);
  asre_axis_model u_axis (.clock_i, .speed_i(speed_o), .lim_neg_i(lim_neg), .enc_a_o(enc_a), .enc_b_o(enc_b),
    .enc_z_o(enc_z), .pre_o(pre), .lim_fwd_o(lim_f), .lim_rev_o(lim_r), .mpos_o(mpos), .cnt1_o(c1),
    .cnt2_o(c2), .cnt4_o(c4));

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bus cycles: entered just after a rising edge; more keeps the strobe up for a write that follows at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit more = 1'b0);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    if (!more)
      wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(posedge clock_i);
    d = rdata_o;
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(what, d, exp);
  endtask

  // A used-up wait bound ends the run
  task automatic tmo(input int n);
    if (n >= 4000)
    begin
      chk("wait bound", n, 0);
      summarize();
    end
  endtask

  task automatic wait_spd(input logic [15:0] v);
    int n;
    n = 0;
    while (speed_o !== v && n < 4000)
    begin
      @(posedge clock_i);
      n++;
    end
    tmo(n);
    chk("speed", {16'h0, speed_o}, {16'h0, v});
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (drive_en_o !== 1'b0 && n < 4000)
    begin
      @(posedge clock_i);
      n++;
    end
    tmo(n);
  endtask

  // Expected speed command: full scale stands for the maximum speed
  function automatic logic [15:0] scale(input logic [15:0] v, input logic neg);
    logic [31:0] p;
    p = (v > vmax_set ? vmax_set : v) * 32'd32767 / vmax_set;
    return neg ? 16'h0 - p[15:0] : p[15:0];
  endfunction

  task automatic t_regs();
    rchk("ctrl", `ASRE_A_CTRL, 32'h0);
    rchk("ppr", `ASRE_A_PPR, 32'h1);
    rchk("dpr", `ASRE_A_DPR, 32'h1);
    rchk("unmapped", 8'h80, 32'h0);
    wr(`ASRE_A_POS, 32'h55);
    rchk("pos ro", `ASRE_A_POS, 32'h0);
    wr(`ASRE_A_VMAX, {16'h0, vmax_set});
    rchk("vmax", `ASRE_A_VMAX, {16'h0, vmax_set});
    wr(`ASRE_A_PPR, 32'hfa0, 1'b1);
    wr(`ASRE_A_DPR, 32'h2710);
    repeat (80) @(posedge clock_i);
    rchk("res x1", `ASRE_A_RESOL, 32'h28000);
    wr(`ASRE_A_CTRL, 32'h10);
    repeat (80) @(posedge clock_i);
    rchk("res x4", `ASRE_A_RESOL, 32'ha000);
    $display("Test registers done");
  endtask

  task automatic t_jog();
    logic [15:0] v [4] = '{16'h7530, 16'h6d60, 16'h6590, 16'h5dc0};
    logic [15:0] e;
    for (int i = 0; i < 5; i++)
    begin
      wr(`ASRE_A_JOG1F + 8'(4 * (i % 4)), i < 4 ? {16'h0, v[i]} : {16'h0, vmax_set}, 1'b1);
      wr(`ASRE_A_CMD, (i % 4) + 1);
      e = scale(i < 4 ? v[i] : vmax_set, i[0]);
      wait_spd(e);
      chk("drive en", drive_en_o, 1'b1);
      rchk("speed reg", `ASRE_A_SPEED, {16'h0, e});
      wr(`ASRE_A_CMD, `ASRE_CMD_STOP);
      wait_spd(16'h0);
    end
    $display("Test jog done");
  endtask

  task automatic t_count();
    logic signed [31:0] p0, p1, e0;
    for (int m = 0; m < 3; m++)
    begin
      wr(`ASRE_A_CTRL, 32'(m) << 3);
      rd(`ASRE_A_POS, p0);
      e0 = m == 0 ? c1 : m == 1 ? c2 : c4;
      for (int k = 1; k < 3; k++)
      begin
        wr(`ASRE_A_CMD, k);
        repeat (k == 1 ? 120 : 80) @(posedge clock_i);
        wr(`ASRE_A_CMD, `ASRE_CMD_STOP);
        wait_spd(16'h0);
      end
      repeat (10) @(posedge clock_i);
      rd(`ASRE_A_POS, p1);
      chk("count", p1 - p0, (m == 0 ? c1 : m == 1 ? c2 : c4) - e0);
    end
    $display("Test counting done");
  endtask

  task automatic t_inc();
    logic signed [31:0] p0, p1;
    wr(`ASRE_A_VINC, 32'h1f40);
    rd(`ASRE_A_POS, p0);
    wr(`ASRE_A_TARGET, 32'h28, 1'b1);
    wr(`ASRE_A_CMD, `ASRE_CMD_INCREL);
    wait_spd(scale(16'h1f40, 1'b0));
    wait_idle();
    rd(`ASRE_A_POS, p1);
    chk("inc rel", 32'(p1 - p0 >= 32'sh28), 32'h1);
    wr(`ASRE_A_TARGET, p0, 1'b1);
    wr(`ASRE_A_CMD, `ASRE_CMD_INCABS);
    wait_spd(scale(16'h1f40, 1'b1));
    wait_idle();
    rd(`ASRE_A_POS, p1);
    chk("inc abs", 32'(p1 <= p0), 32'h1);
    $display("Test incremental done");
  endtask

  // Reference run; rev also selects negative switches and coded coordinates
  task automatic t_ref(input logic rev, input logic [31:0] ref_w, input logic signed [31:0] ref_v);
    logic [31:0] d;
    wr(`ASRE_A_CTRL, {27'h0, 2'h2, rev, rev, rev}, 1'b1);
    lim_neg <= rev;
    wr(`ASRE_A_REFPT, ref_w, 1'b1);
    wr(`ASRE_A_VREF1, 32'h4e20, 1'b1);
    wr(`ASRE_A_VREF2, 32'h2710, 1'b1);
    wr(`ASRE_A_CMD, `ASRE_CMD_REF);
    wait_spd(scale(16'h4e20, !rev));
    wait_spd(scale(16'h4e20, rev));
    wait_spd(scale(16'h2710, rev));
    chk("precontact", pre, 1'b1);
    wait_idle();
    repeat (10) @(posedge clock_i);
    rd(`ASRE_A_STATUS, d);
    chk("ref ok", d[1], 1'b1);
    chk("limit flag", d[rev ? 2 : 3], 1'b1);
    rd(`ASRE_A_POS, d);
    chk("ref pos", d, ref_v + mpos - 32'sh39);
    $display("Test reference done");
  endtask

  initial
  begin
    repeat (4) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    t_regs();
    t_jog();
    t_count();
    t_inc();
    t_ref(1'b0, 32'h7b, 32'sh7b);
    t_ref(1'b1, 32'h80000123, -32'sh7b);
    summarize();
  end
endmodule

`default_nettype wire
